// ==== rfsc_pkg.sv ====
// Shared constants and carrier types for the RF supply, DAC and clock enable control.
package rfsc_pkg;

  // ==========================================================================
  // Widths and values after reset
  // ==========================================================================
  localparam int unsigned PA_CODE_W     = 8;
  localparam int unsigned TRIM_CODE_W   = 12;
  localparam int unsigned TRIM_HIGH_W   = 4;
  localparam int unsigned TRIM_LOW_W    = 8;
  localparam int unsigned SER_DATA_W    = 8;
  localparam int unsigned NUM_PA_OUTS   = 3;
  localparam int unsigned NUM_CLK_OUTS  = 3;

  localparam logic [7:0]  PA_CODE_RESET   = 8'h80;
  localparam logic [11:0] TRIM_CODE_RESET = 12'h800;
  localparam logic [7:0]  CTRL_RESET      = 8'h3F;

  // ==========================================================================
  // Register selects on the read/write serial port
  // ==========================================================================
  localparam logic [1:0] SEL_PA_REF    = 2'h0;
  localparam logic [1:0] SEL_TRIM_HIGH = 2'h1;
  localparam logic [1:0] SEL_TRIM_LOW  = 2'h2;
  localparam logic [1:0] SEL_CONTROL   = 2'h3;

  // ==========================================================================
  // Control register bit positions
  // ==========================================================================
  localparam int unsigned CTRL_TRIM_PWR_BIT  = 0;
  localparam int unsigned CTRL_CLK2_EN_BIT   = 1;
  localparam int unsigned CTRL_CLK3_EN_BIT   = 2;
  localparam int unsigned CTRL_AUX3_PWR_BIT  = 3;
  localparam int unsigned CTRL_AUX3_MODE_BIT = 4;
  localparam int unsigned CTRL_AUX_SRC_BIT   = 5;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic master_enable;
    logic io_supply_present;
    logic control_reset_n;
    logic sysclk_request;
    logic second_clock_request;
    logic rx_front_end_on;
    logic tx_prepare;
    logic tx_active;
    logic band_select_a;
    logic band_select_b;
    logic osc_overcurrent;
  } rfsc_pins_t;

  typedef struct packed {
    logic aux_mode_source;
    logic aux3_mode_select;
    logic aux3_power_enable;
    logic clock_out3_enable;
    logic clock_out2_enable;
    logic trim_dac_power_enable;
  } rfsc_ctrl_t;

  typedef struct packed {
    logic                   core_on;
    logic                   buffer_on;
    logic [NUM_PA_OUTS-1:0] out_enable;
    logic [NUM_PA_OUTS-1:0] out_pulldown;
  } rfsc_pa_out_t;

endpackage : rfsc_pkg

// ==== rfsc_pa_ref_decode.sv ====
// Pin decode for the power-amplifier reference DAC core, buffer and output select.
`timescale 1ns/1ps
module rfsc_pa_ref_decode
(
  input  wire logic                  master_enable_i, // Master enable, high on
  input  wire logic                  tx_prepare_i,    // Transmit prepare pin
  input  wire logic                  tx_active_i,     // Transmit active pin
  input  wire logic                  band_select_a_i, // Band select 1 pin
  input  wire logic                  band_select_b_i, // Band select 2 pin
  output rfsc_pkg::rfsc_pa_out_t     pa_o             // Core, buffer and output enables
);

  logic [rfsc_pkg::NUM_PA_OUTS-1:0] band_onehot;
  logic                             core_on;
  logic                             buffer_on;

  // ==========================================================================
  // Band decode
  // ==========================================================================
  always_comb
  begin
    band_onehot = '0;
    if (!band_select_a_i && !band_select_b_i)
    begin
      band_onehot[0] = 1'b1;
    end
    else if (band_select_a_i && !band_select_b_i)
    begin
      band_onehot[1] = 1'b1;
    end
    else if (!band_select_a_i && band_select_b_i)
    begin
      band_onehot[2] = 1'b1;
    end
  end

  // The core stays powered while master enable and prepare are high so the code settles before
  // transmit; the buffer only drives once transmit is active on a legal band.
  assign core_on   = master_enable_i && tx_prepare_i;
  assign buffer_on = core_on && tx_active_i && (band_onehot != '0);

  always_comb
  begin
    pa_o.core_on      = core_on;
    pa_o.buffer_on    = buffer_on;
    pa_o.out_enable   = buffer_on ? band_onehot : '0;
    pa_o.out_pulldown = (core_on && !buffer_on) ? '1 : '0;
  end

endmodule : rfsc_pa_ref_decode

// ==== rfsc_trim_seq.sv ====
// Frequency-trim code register with ordered two-step and single-step write paths.
`timescale 1ns/1ps
module rfsc_trim_seq
(
  input  wire logic                                clk_sys_i,     // System clock
  input  wire logic                                reset_n_i,     // Synchronous reset, low
  input  wire logic                                clear_i,       // Return to default, high
  input  wire logic                                high_wr_i,     // High part written, pulse
  input  wire logic                                low_wr_i,      // Low part written, pulse
  input  wire logic [rfsc_pkg::SER_DATA_W-1:0]     wdata_i,       // Serial write data
  input  wire logic                                wo_wr_i,       // Whole code written, pulse
  input  wire logic [rfsc_pkg::TRIM_CODE_W-1:0]    wo_code_i,     // Whole code value
  output logic      [rfsc_pkg::TRIM_CODE_W-1:0]    trim_code_o,   // Applied trim code
  output logic                                     pending_o      // High part staged
);

  typedef struct packed {
    logic                               pending;
    logic [rfsc_pkg::TRIM_HIGH_W-1:0]   staged_high;
    logic [rfsc_pkg::TRIM_CODE_W-1:0]   code;
  } rfsc_trim_state_t;

  rfsc_trim_state_t state;
  rfsc_trim_state_t next_state;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_state = state;
    if (clear_i)
    begin
      next_state.pending     = 1'b0;
      next_state.staged_high = '0;
      next_state.code        = rfsc_pkg::TRIM_CODE_RESET;
    end
    else if (wo_wr_i)
    begin
      // A whole-code write supersedes any half-finished two-step update.
      next_state.code    = wo_code_i;
      next_state.pending = 1'b0;
    end
    else if (low_wr_i && state.pending)
    begin
      next_state.code    = {state.staged_high, wdata_i[rfsc_pkg::TRIM_LOW_W-1:0]};
      next_state.pending = 1'b0;
    end
    else if (high_wr_i)
    begin
      next_state.staged_high = wdata_i[rfsc_pkg::TRIM_HIGH_W-1:0];
      next_state.pending     = 1'b1;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state.pending     <= 1'b0;
      state.staged_high <= '0;
      state.code        <= rfsc_pkg::TRIM_CODE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign trim_code_o = state.code;
  assign pending_o   = state.pending;

endmodule : rfsc_trim_seq

// ==== rfsc_ctrl.sv ====
// Top of the RF supply, DAC and clock enable control: pins, codes and decodes.
//
// Summary of operation
// - Oscillator supply on only while master enable and clock request are high.
// - Oscillator supply output is cut while overcurrent is flagged, restored after.
// - Reference DAC core powers from master enable and the transmit-prepare pin.
// - Band selects pick one reference output: 00 first, a second, b third.
// - Both band selects high: buffer off, outputs pulled low, core kept on.
// - Prepare high, active low: buffer off, outputs pulled low, core kept on.
// - Reference DAC power and output select come from pins only.
// - Reference code is kept across reference DAC power cycles.
// - Control reset low or master enable low restores reference code default.
// - Trim DAC on when master enable, clock request and power bit high.
// - Read/write port applies trim only after high then low part writes.
// - Write-only port applies a complete trim code in one access.
// - Clock request or trim power bit low: trim output off, pulled low.
// - Trim DAC resumes at the retained code after powering up again.
// - Control reset low or master enable low restores trim code default.
// - First clock output on with master enable and clock request alone.
// - Second clock output needs its enable bit and second clock request too.
// - Third clock output needs its enable bit and receive front-end pin too.
// - Third auxiliary regulator on with master enable and its power bit, default one.
// - Its mode follows mode bit or second clock request per source bit; normal if no I/O supply.
`timescale 1ns/1ps
module rfsc_ctrl
(
  input  wire logic                              clk_sys_i,              // System clock
  input  wire logic                              reset_n_i,              // Sync reset, low
  input  rfsc_pkg::rfsc_pins_t                   pins_i,                 // Host control pins
  input  wire logic                              rw_wr_i,                // R/W port write pulse
  input  wire logic                              rw_rd_i,                // R/W port read pulse
  input  wire logic [1:0]                        rw_sel_i,               // R/W register select
  input  wire logic [rfsc_pkg::SER_DATA_W-1:0]   rw_wdata_i,             // R/W write data
  input  wire logic                              wo_wr_i,                // Write-only pulse
  input  wire logic [rfsc_pkg::TRIM_CODE_W-1:0]  wo_trim_code_i,         // Write-only trim
  output logic      [rfsc_pkg::SER_DATA_W-1:0]   rw_rdata_o,             // Read data, reg
  output logic                                   rw_rvalid_o,            // Read data valid
  output logic                                   oscillator_supply_on_o, // Osc supply on
  output rfsc_pkg::rfsc_pa_out_t                 pa_o,                   // Reference DAC
  output logic      [rfsc_pkg::PA_CODE_W-1:0]    pa_ref_code_o,          // Ref code, reg
  output logic                                   freq_trim_on_o,         // Trim DAC on
  output logic                                   freq_trim_pulldown_o,   // Trim to ground
  output logic      [rfsc_pkg::TRIM_CODE_W-1:0]  trim_code_o,            // Trim code, reg
  output logic                                   trim_pending_o,         // High part staged
  output logic      [rfsc_pkg::NUM_CLK_OUTS-1:0] clock_out_enable_o,     // Clock buffers
  output logic                                   aux3_on_o,              // Aux3 supply on
  output logic                                   aux3_normal_mode_o,     // Aux3 normal mode
  output rfsc_pkg::rfsc_ctrl_t                   ctrl_o                  // Control bits
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [rfsc_pkg::PA_CODE_W-1:0]  pa_code;
    rfsc_pkg::rfsc_ctrl_t            ctrl;
    logic [rfsc_pkg::SER_DATA_W-1:0] rdata;
    logic                            rvalid;
  } rfsc_main_state_t;

  rfsc_main_state_t state;
  rfsc_main_state_t next_state;

  logic                               soft_clear;
  logic                               write_ok;
  logic                               trim_high_wr;
  logic                               trim_low_wr;
  logic                               clock_base;
  logic [rfsc_pkg::TRIM_CODE_W-1:0]   trim_code;
  logic                               trim_pending;
  logic [rfsc_pkg::NUM_CLK_OUTS-1:0]  clk_extra;
  logic [rfsc_pkg::NUM_CLK_OUTS-1:0]  clk_bit_en;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Every clock-domain block shares the same gate of master enable and request.
  function automatic logic rfsc_clock_gate
  (
    input logic master_enable,
    input logic sysclk_request
  );
    return master_enable && sysclk_request;
  endfunction : rfsc_clock_gate

  function automatic rfsc_pkg::rfsc_ctrl_t rfsc_ctrl_unpack
  (
    input logic [rfsc_pkg::SER_DATA_W-1:0] data
  );
    rfsc_pkg::rfsc_ctrl_t c;
    c.trim_dac_power_enable = data[rfsc_pkg::CTRL_TRIM_PWR_BIT];
    c.clock_out2_enable     = data[rfsc_pkg::CTRL_CLK2_EN_BIT];
    c.clock_out3_enable     = data[rfsc_pkg::CTRL_CLK3_EN_BIT];
    c.aux3_power_enable     = data[rfsc_pkg::CTRL_AUX3_PWR_BIT];
    c.aux3_mode_select      = data[rfsc_pkg::CTRL_AUX3_MODE_BIT];
    c.aux_mode_source       = data[rfsc_pkg::CTRL_AUX_SRC_BIT];
    return c;
  endfunction : rfsc_ctrl_unpack

  function automatic logic [rfsc_pkg::SER_DATA_W-1:0] rfsc_ctrl_pack
  (
    input rfsc_pkg::rfsc_ctrl_t c
  );
    logic [rfsc_pkg::SER_DATA_W-1:0] d;
    d                                  = '0;
    d[rfsc_pkg::CTRL_TRIM_PWR_BIT]     = c.trim_dac_power_enable;
    d[rfsc_pkg::CTRL_CLK2_EN_BIT]      = c.clock_out2_enable;
    d[rfsc_pkg::CTRL_CLK3_EN_BIT]      = c.clock_out3_enable;
    d[rfsc_pkg::CTRL_AUX3_PWR_BIT]     = c.aux3_power_enable;
    d[rfsc_pkg::CTRL_AUX3_MODE_BIT]    = c.aux3_mode_select;
    d[rfsc_pkg::CTRL_AUX_SRC_BIT]      = c.aux_mode_source;
    return d;
  endfunction : rfsc_ctrl_pack

  // ==========================================================================
  // Serial write qualification
  // ==========================================================================
  // Control reset or master enable low holds the code and control registers at default and
  // serial writes are ignored meanwhile, so no write can slip in during reset.
  assign soft_clear   = !pins_i.control_reset_n || !pins_i.master_enable;
  assign write_ok     = rw_wr_i && !soft_clear;
  assign trim_high_wr = write_ok && (rw_sel_i == rfsc_pkg::SEL_TRIM_HIGH);
  assign trim_low_wr  = write_ok && (rw_sel_i == rfsc_pkg::SEL_TRIM_LOW);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    if (soft_clear)
    begin
      next_state.pa_code = rfsc_pkg::PA_CODE_RESET;
      next_state.ctrl    = rfsc_ctrl_unpack(rfsc_pkg::CTRL_RESET);
    end
    else if (write_ok)
    begin
      if (rw_sel_i == rfsc_pkg::SEL_PA_REF)
      begin
        next_state.pa_code = rw_wdata_i;
      end
      else if (rw_sel_i == rfsc_pkg::SEL_CONTROL)
      begin
        next_state.ctrl = rfsc_ctrl_unpack(rw_wdata_i);
      end
    end
    if (rw_rd_i)
    begin
      next_state.rvalid = 1'b1;
      if (rw_sel_i == rfsc_pkg::SEL_PA_REF)
      begin
        next_state.rdata = state.pa_code;
      end
      else if (rw_sel_i == rfsc_pkg::SEL_TRIM_HIGH)
      begin
        next_state.rdata = {{(rfsc_pkg::SER_DATA_W - rfsc_pkg::TRIM_HIGH_W){1'b0}},
                            trim_code[rfsc_pkg::TRIM_CODE_W-1:rfsc_pkg::TRIM_LOW_W]};
      end
      else if (rw_sel_i == rfsc_pkg::SEL_TRIM_LOW)
      begin
        next_state.rdata = trim_code[rfsc_pkg::TRIM_LOW_W-1:0];
      end
      else
      begin
        next_state.rdata = rfsc_ctrl_pack(state.ctrl);
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // The reference code is not tied to the DAC power state, so it survives a power cycle of
  // the DAC by the prepare pin and the output returns at the programmed level.
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state.pa_code <= rfsc_pkg::PA_CODE_RESET;
      state.ctrl    <= rfsc_ctrl_unpack(rfsc_pkg::CTRL_RESET);
      state.rdata   <= '0;
      state.rvalid  <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Trim code sequencing
  // ==========================================================================
  rfsc_trim_seq u_trim_seq
  (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .clear_i     (soft_clear),
    .high_wr_i   (trim_high_wr),
    .low_wr_i    (trim_low_wr),
    .wdata_i     (rw_wdata_i),
    .wo_wr_i     (wo_wr_i && !soft_clear),
    .wo_code_i   (wo_trim_code_i),
    .trim_code_o (trim_code),
    .pending_o   (trim_pending)
  );

  // ==========================================================================
  // Reference DAC decode
  // ==========================================================================
  // Only pins reach this decoder; nothing from the serial registers does.
  rfsc_pa_ref_decode u_pa_ref_decode
  (
    .master_enable_i (pins_i.master_enable),
    .tx_prepare_i    (pins_i.tx_prepare),
    .tx_active_i     (pins_i.tx_active),
    .band_select_a_i (pins_i.band_select_a),
    .band_select_b_i (pins_i.band_select_b),
    .pa_o            (pa_o)
  );

  // ==========================================================================
  // Oscillator supply and trim DAC enables
  // ==========================================================================
  assign clock_base = rfsc_clock_gate(pins_i.master_enable, pins_i.sysclk_request);

  // Overcurrent is a live indication, so the output returns on its own once
  // the condition clears, with no latch to be cleared by software.
  assign oscillator_supply_on_o = clock_base && !pins_i.osc_overcurrent;

  assign freq_trim_on_o       = clock_base && state.ctrl.trim_dac_power_enable;
  assign freq_trim_pulldown_o = !freq_trim_on_o;

  // ==========================================================================
  // Clock buffer enables
  // ==========================================================================
  assign clk_extra  = {pins_i.rx_front_end_on, pins_i.second_clock_request, 1'b1};
  assign clk_bit_en = {state.ctrl.clock_out3_enable, state.ctrl.clock_out2_enable, 1'b1};

  generate
    for (genvar i = 0; i < rfsc_pkg::NUM_CLK_OUTS; i++)
    begin : g_clk_out
      assign clock_out_enable_o[i] = clock_base && clk_bit_en[i] && clk_extra[i];
    end
  endgenerate

  // ==========================================================================
  // Third auxiliary regulator
  // ==========================================================================
  // With the I/O supply absent the host cannot drive the mode pin reliably,
  // so the regulator falls back to normal mode in that case.
  assign aux3_on_o = pins_i.master_enable && state.ctrl.aux3_power_enable;

  always_comb
  begin
    if (!aux3_on_o)
    begin
      aux3_normal_mode_o = 1'b0;
    end
    else if (!pins_i.io_supply_present)
    begin
      aux3_normal_mode_o = 1'b1;
    end
    else if (state.ctrl.aux_mode_source)
    begin
      aux3_normal_mode_o = state.ctrl.aux3_mode_select;
    end
    else
    begin
      aux3_normal_mode_o = pins_i.second_clock_request;
    end
  end

  // ==========================================================================
  // Outputs from registers
  // ==========================================================================
  assign pa_ref_code_o  = state.pa_code;
  assign trim_code_o    = trim_code;
  assign trim_pending_o = trim_pending;
  assign rw_rdata_o     = state.rdata;
  assign rw_rvalid_o    = state.rvalid;
  assign ctrl_o         = state.ctrl;

endmodule : rfsc_ctrl

// ==== rfsc_ctrl_asserts.sv ====
// Port checks for the RF supply, DAC and clock enable control.
`timescale 1ns/1ps
module rfsc_ctrl_asserts
(
  input wire logic             clk_sys_i,              // Clock
  input wire logic             reset_n_i,              // Reset, low
  input rfsc_pkg::rfsc_pins_t  pins_i,                 // Pins
  input wire logic             rw_wr_i,                // Write
  input wire logic [1:0]       rw_sel_i,               // Select
  input wire logic [7:0]       rw_wdata_i,             // Data
  input wire logic             wo_wr_i,                // Whole write
  input wire logic [11:0]      wo_trim_code_i,         // Whole code
  input wire logic             oscillator_supply_on_o, // Osc
  input rfsc_pkg::rfsc_pa_out_t pa_o,                  // Ref DAC
  input wire logic [7:0]       pa_ref_code_o,          // Ref code
  input wire logic             freq_trim_on_o,         // Trim on
  input wire logic             freq_trim_pulldown_o,   // Trim low
  input wire logic [11:0]      trim_code_o,            // Trim code
  input wire logic             trim_pending_o,         // Staged
  input wire logic [2:0]       clock_out_enable_o,     // Clocks
  input rfsc_pkg::rfsc_ctrl_t  ctrl_o                  // Control
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic me, sy, a, b, sc;
  assign me = pins_i.master_enable;
  assign sy = pins_i.sysclk_request;
  assign a = pins_i.band_select_a;
  assign b = pins_i.band_select_b;
  assign sc = !me || !pins_i.control_reset_n;
  a_osc_gate: assert property (oscillator_supply_on_o ==
    (me && sy && !pins_i.osc_overcurrent)) else $error("osc supply gate");
  a_trim_gate: assert property (freq_trim_pulldown_o == !freq_trim_on_o &&
    freq_trim_on_o == (me && sy && ctrl_o.trim_dac_power_enable)) else $error("trim gate");
  a_clock_gate: assert property (clock_out_enable_o == {me && sy && ctrl_o.clock_out3_enable &&
    pins_i.rx_front_end_on, me && sy && ctrl_o.clock_out2_enable && pins_i.second_clock_request,
    me && sy}) else $error("clock gate");
  a_pa_core: assert property (pa_o.core_on == (me && pins_i.tx_prepare))
    else $error("ref core");
  a_pa_select: assert property (pa_o.buffer_on |-> pins_i.tx_active && !(a && b) &&
    pa_o.out_enable == (a ? 3'b010 : b ? 3'b100 : 3'b001)) else $error("ref select");
  a_pa_pulldown: assert property (pa_o.core_on && (!pins_i.tx_active || (a && b)) |->
    !pa_o.buffer_on && pa_o.out_enable == 3'b000 && pa_o.out_pulldown == 3'b111)
    else $error("ref pulldown");
  a_clear_codes: assert property (sc |=> pa_ref_code_o == 8'h80 &&
    trim_code_o == 12'h800 && !trim_pending_o) else $error("soft clear");
  a_trim_order: assert property (rw_wr_i && rw_sel_i == 2'h2 && !trim_pending_o &&
    !wo_wr_i && !sc |=> $stable(trim_code_o)) else $error("trim order");
  a_trim_commit: assert property (rw_wr_i && rw_sel_i == 2'h2 && trim_pending_o &&
    !wo_wr_i && !sc |=> trim_code_o[7:0] == $past(rw_wdata_i)) else $error("trim commit");
  a_wo_whole: assert property (wo_wr_i && !sc |=> trim_code_o == $past(wo_trim_code_i))
    else $error("whole code");
endmodule : rfsc_ctrl_asserts

// ==== rfsc_host_model.sv ====
// Host model that drives the control pins.
`timescale 1ns/1ps
module rfsc_host_model
(
  input  wire logic           clk_sys_i,   // Clock
  input  rfsc_pkg::rfsc_pins_t req_i,      // Wanted levels
  output rfsc_pkg::rfsc_pins_t pins_o = '0 // Driven levels
);
  // A band change under a live reference DAC parks the DAC for one cycle first.
  always @(posedge clk_sys_i)
  begin
    if (pins_o.tx_prepare && {pins_o.band_select_a, pins_o.band_select_b} !=
        {req_i.band_select_a, req_i.band_select_b})
    begin
      pins_o.tx_prepare <= 1'b0;
      pins_o.tx_active  <= 1'b0;
    end
    else
      pins_o <= req_i;
  end
endmodule : rfsc_host_model

// ==== tb_rfsc_ctrl.sv ====
// Self-checking testbench for the RF supply, DAC and clock enable control.
`timescale 1ns/1ps
module tb_rfsc_ctrl;
  logic                   clk_sys_i = 1'b0, reset_n_i = 1'b0, rw_wr_i = 1'b0, rw_rd_i = 1'b0;
  logic                   wo_wr_i = 1'b0, rw_rvalid_o, oscillator_supply_on_o, core, bon;
  logic                   freq_trim_on_o, freq_trim_pulldown_o, trim_pending_o;
  logic                   aux3_on_o, aux3_normal_mode_o;
  logic [1:0]             rw_sel_i = 2'h0;
  logic [7:0]             rw_wdata_i = 8'h00, rw_rdata_o, pa_ref_code_o;
  logic [11:0]            wo_trim_code_i = 12'h000, trim_code_o;
  logic [2:0]             clock_out_enable_o, oe;
  rfsc_pkg::rfsc_pins_t   req = '0, pins, p;
  rfsc_pkg::rfsc_pa_out_t pa_o;
  rfsc_pkg::rfsc_ctrl_t   ctrl_o;
  int                     n_errors = 0, n_tests = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  rfsc_host_model i_rfsc_host_model (.clk_sys_i, .req_i(req), .pins_o(pins));
  rfsc_ctrl i_rfsc_ctrl (.clk_sys_i, .reset_n_i, .pins_i(pins), .rw_wr_i, .rw_rd_i, .rw_sel_i,
    .rw_wdata_i, .wo_wr_i, .wo_trim_code_i, .rw_rdata_o, .rw_rvalid_o, .oscillator_supply_on_o,
    .pa_o, .pa_ref_code_o, .freq_trim_on_o, .freq_trim_pulldown_o, .trim_code_o, .trim_pending_o,
    .clock_out_enable_o, .aux3_on_o, .aux3_normal_mode_o, .ctrl_o);
  task automatic ck(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck
  task automatic go(input rfsc_pkg::rfsc_pins_t v);
    @(posedge clk_sys_i);
    req <= v;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : go
  // Write when w is high, read otherwise; results are settled on return.
  task automatic acc(input logic w, input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys_i);
    rw_wr_i <= w;
    rw_rd_i <= !w;
    rw_sel_i <= s;
    rw_wdata_i <= d;
    @(posedge clk_sys_i);
    rw_wr_i <= 1'b0;
    rw_rd_i <= 1'b0;
    #1;
  endtask : acc
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    p = '0;
    {p.master_enable, p.io_supply_present, p.control_reset_n, p.sysclk_request} = 4'hF;
    req = p;
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1;
    ck({pa_ref_code_o, trim_code_o}, 24'h08_0800);
    acc(1'b0, 2'h3, 8'h00);
    ck({rw_rvalid_o, rw_rdata_o}, 9'h13F);
    acc(1'b1, 2'h0, 8'h5A);
    ck(pa_ref_code_o, 8'h5A);
    acc(1'b1, 2'h2, 8'hA7);
    ck({trim_pending_o, trim_code_o}, 13'h0800);
    acc(1'b1, 2'h1, 8'h05);
    ck(trim_pending_o, 1'b1);
    acc(1'b1, 2'h2, 8'hA7);
    ck({trim_pending_o, trim_code_o}, 13'h05A7);
    acc(1'b0, 2'h1, 8'h00);
    ck({rw_rvalid_o, rw_rdata_o}, 9'h105);
    @(posedge clk_sys_i);
    wo_wr_i <= 1'b1;
    wo_trim_code_i <= 12'h123;
    @(posedge clk_sys_i);
    wo_wr_i <= 1'b0;
    #1;
    ck(trim_code_o, 12'h123);
    for (int i = 0; i < 16; i++)
    begin
      {p.tx_prepare, p.tx_active, p.band_select_a, p.band_select_b} = i[3:0];
      go(p);
      core = i[3];
      bon = core & i[2] & !(i[1] & i[0]);
      oe = bon ? (i[1] ? 3'b010 : i[0] ? 3'b100 : 3'b001) : 3'b000;
      ck(pa_o, {core, bon, oe, {3{core & !bon}}});
    end
    ck(pa_ref_code_o, 8'h5A);
    acc(1'b0, 2'h0, 8'h00);
    ck({rw_rvalid_o, rw_rdata_o}, 9'h15A);
    for (int j = 0; j < 8; j++)
    begin
      {p.rx_front_end_on, p.second_clock_request, p.sysclk_request} = j[2:0];
      go(p);
      ck(clock_out_enable_o, {j[0] & j[2], j[0] & j[1], j[0]});
      ck(oscillator_supply_on_o, j[0]);
    end
    p.osc_overcurrent = 1'b1;
    go(p);
    ck({oscillator_supply_on_o, clock_out_enable_o}, 4'h7);
    p.osc_overcurrent = 1'b0;
    go(p);
    ck(oscillator_supply_on_o, 1'b1);
    acc(1'b1, 2'h3, 8'h39);
    ck({ctrl_o, clock_out_enable_o}, 9'h1C9);
    acc(1'b1, 2'h3, 8'h3E);
    ck({freq_trim_on_o, freq_trim_pulldown_o}, 2'b01);
    acc(1'b1, 2'h3, 8'h3F);
    ck({freq_trim_on_o, trim_code_o}, 13'h1123);
    acc(1'b1, 2'h3, 8'h2F);
    ck(aux3_normal_mode_o, 1'b0);
    acc(1'b1, 2'h3, 8'h1F);
    ck(aux3_normal_mode_o, 1'b1);
    p.second_clock_request = 1'b0;
    go(p);
    ck(aux3_normal_mode_o, 1'b0);
    acc(1'b1, 2'h3, 8'h37);
    ck(aux3_on_o, 1'b0);
    p.control_reset_n = 1'b0;
    go(p);
    acc(1'b1, 2'h0, 8'h33);
    ck({pa_ref_code_o, trim_code_o}, 24'h08_0800);
    {p.control_reset_n, p.master_enable} = 2'b10;
    go(p);
    ck({oscillator_supply_on_o, freq_trim_on_o, clock_out_enable_o, aux3_on_o, pa_o}, '0);
    complete_run();
  end
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_errors++;
    complete_run();
  end
endmodule : tb_rfsc_ctrl
bind rfsc_ctrl rfsc_ctrl_asserts i_rfsc_ctrl_asserts (.clk_sys_i, .reset_n_i, .pins_i, .rw_wr_i,
  .rw_sel_i, .rw_wdata_i, .wo_wr_i, .wo_trim_code_i, .oscillator_supply_on_o, .pa_o,
  .pa_ref_code_o, .freq_trim_on_o, .freq_trim_pulldown_o, .trim_code_o, .trim_pending_o,
  .clock_out_enable_o, .ctrl_o);
